// ---- hdr_pkg.sv ----
// Constants and types shared by the HDLC data link receiver files
package hdr_pkg;
  localparam int HDR_FIFO_DEPTH = 128;
  localparam int HDR_ENTRY_W = 13;
  localparam int HDR_ADR_W = 8;
  localparam logic [7:0] HDR_FLAG = 8'h7e;
  localparam logic [7:0] HDR_BCAST = 8'hff;
  localparam logic [7:0] HDR_SAPI_MASK = 8'hfc;
  localparam logic [15:0] HDR_CRC_INIT = 16'hffff;
  localparam logic [15:0] HDR_CRC_POLY = 16'h8408;
  localparam logic [15:0] HDR_CRC_GOOD = 16'hf0b8;
  localparam logic [2:0] HDR_ONES_STUFF = 3'h5;
  localparam logic [2:0] HDR_ONES_PRE_ABORT = 3'h6;
  localparam logic [2:0] HDR_ONES_MAX = 3'h7;
  localparam logic [3:0] HDR_BITS_BYTE = 4'h8;
  localparam logic [3:0] HDR_BITS_LAST = 4'h7;
  // Register byte offsets
  localparam logic [7:0] HDR_OFF_CTRL = 8'h00;
  localparam logic [7:0] HDR_OFF_ADDR = 8'h04;
  localparam logic [7:0] HDR_OFF_THRESH = 8'h08;
  localparam logic [7:0] HDR_OFF_STATUS = 8'h0c;
  localparam logic [7:0] HDR_OFF_DATA = 8'h10;
  localparam logic [7:0] HDR_OFF_INT_STAT = 8'h14;
  localparam logic [7:0] HDR_OFF_INT_MASK = 8'h18;
  // Control fields
  localparam int HDR_CTRL_EN = 0;
  localparam int HDR_CTRL_AM_EN = 1;
  localparam int HDR_CTRL_SAPI = 2;
  localparam int HDR_CTRL_SRC_LO = 3;
  localparam logic [4:0] HDR_CTRL_RST = 5'h00;
  localparam logic [7:0] HDR_ADDR_RST = 8'h00;
  localparam logic [7:0] HDR_THR_RST = 8'h40;
  // FIFO entry tag positions above the data byte
  localparam int HDR_TAG_ABORT = 8;
  localparam int HDR_TAG_FIRST = 9;
  localparam int HDR_TAG_EOM = 10;
  localparam int HDR_TAG_FCSOK = 11;
  localparam int HDR_TAG_NONINT = 12;
  // Interrupt status and mask positions
  localparam int HDR_INT_W = 4;
  localparam int HDR_INT_THR = 0;
  localparam int HDR_INT_EOM = 1;
  localparam int HDR_INT_ABT = 2;
  localparam int HDR_INT_OVR = 3;
  // Status register positions
  localparam int HDR_ST_EMPTY = 0;
  localparam int HDR_ST_OVR = 1;
  localparam int HDR_ST_IRQ = 2;
  localparam int HDR_ST_WFIRST = 3;
  localparam int HDR_ST_WEOM = 4;
  localparam int HDR_ST_TAG_LO = 5;

  typedef enum logic [1:0] {HDR_SRC_FDL, HDR_SRC_SA, HDR_SRC_TS,
                            HDR_SRC_OFF} hdr_src_t;
  typedef enum logic [1:0] {HDR_HUNT, HDR_IDLE, HDR_DATA} hdr_state_t;
endpackage

// ---- hdr_fifo.sv ----
// Flip-flop FIFO holding received bytes with their tags
`timescale 1ns/1ps
`default_nettype none
module hdr_fifo
  import hdr_pkg::*;
#(
  parameter int WIDTH = HDR_ENTRY_W,
  parameter int DEPTH = HDR_FIFO_DEPTH,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  output logic [AW:0] level
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hdr_fifo_st_t;

  hdr_fifo_st_t r;
  hdr_fifo_st_t n;
  logic do_wr;
  logic do_rd;

  assign wr_ready = r.cnt != (AW+1)'(DEPTH);
  assign rd_valid = r.cnt != '0;
  assign rd_data = r.mem[r.rp];
  assign level = r.cnt;

  always_comb begin
    n = r;
    do_wr = wr_valid && wr_ready;
    do_rd = rd_valid && rd_ready;
    if (clr) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end else begin
      if (do_wr) begin
        n.mem[r.wp] = wr_data;
        n.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
      end
      if (do_rd) begin
        n.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
      end
      if (do_wr && !do_rd) begin
        n.cnt = r.cnt + 1'b1;
      end else if (!do_wr && do_rd) begin
        n.cnt = r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// ---- hdr_hdlc_receiver_unit.sv ----
// HDLC data link receiver with Wishbone registers and receive FIFO
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hdr_hdlc_receiver_unit
  import hdr_pkg::*;
#(
  parameter int FIFO_DEPTH = HDR_FIFO_DEPTH,
  localparam int LW = $clog2(FIFO_DEPTH) + 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic fdl_bit,
  input wire logic fdl_bit_en,
  input wire logic sa_bit,
  input wire logic sa_bit_en,
  input wire logic ts_bit,
  input wire logic ts_bit_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [HDR_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq
);
  typedef struct packed {
    hdr_state_t state;
    logic [2:0] ones;
    logic [7:0] raw;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] pend;
    logic pend_first;
    logic store;
    logic [15:0] crc;
    logic [4:0] ctrl;
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic [7:0] thr;
    logic [HDR_INT_W-1:0] imask;
    logic [HDR_INT_W-1:0] istat;
    logic wr_first;
    logic wr_eom;
    logic [4:0] last_tag;
    logic ack;
    logic [31:0] dat;
  } hdr_st_t;

  hdr_st_t r;
  hdr_st_t n;
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rx_bit;
  logic rx_en;
  logic [7:0] raw_n;
  logic is_flag;
  logic is_abort;
  logic stuffed;
  logic fifo_wr;
  logic fifo_wready;
  logic [HDR_ENTRY_W-1:0] fifo_wd;
  logic fifo_rv;
  logic fifo_pop;
  logic [HDR_ENTRY_W-1:0] fifo_rd;
  logic [LW-1:0] fifo_level;
  logic acc;
  logic [7:0] adr;
  logic [31:0] wm;
  logic [31:0] st;

  function automatic logic [15:0] hdr_crc_byte(input logic [15:0] c,
                                               input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ HDR_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  function automatic logic hdr_addr_hit(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic sapi);
    logic [7:0] m;
    m = sapi ? HDR_SAPI_MASK : HDR_BCAST;
    return (a & m) == (b & m);
  endfunction

  function automatic logic [31:0] hdr_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] x;
    x = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        x[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return x;
  endfunction

  // Two-flop release of the asynchronous reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  hdr_fifo #(
    .WIDTH(HDR_ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(rst_sync_reg),
    .clr(!r.ctrl[HDR_CTRL_EN]),
    .wr_valid(fifo_wr),
    .wr_ready(fifo_wready),
    .wr_data(fifo_wd),
    .rd_valid(fifo_rv),
    .rd_ready(fifo_pop),
    .rd_data(fifo_rd),
    .level(fifo_level)
  );

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;
  assign irq = |(r.istat & r.imask);
  assign acc = wb_cyc_i && wb_stb_i;
  assign adr = {wb_adr_i[7:2], 2'b00};

  always_comb begin
    n = r;
    fifo_wr = 1'b0;
    fifo_wd = '0;
    fifo_pop = 1'b0;
    rx_bit = 1'b0;
    rx_en = 1'b0;
    wm = hdr_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    case (hdr_src_t'(r.ctrl[HDR_CTRL_SRC_LO +: 2]))
      HDR_SRC_FDL: begin
        rx_bit = fdl_bit;
        rx_en = fdl_bit_en;
      end
      HDR_SRC_SA: begin
        rx_bit = sa_bit;
        rx_en = sa_bit_en;
      end
      HDR_SRC_TS: begin
        rx_bit = ts_bit;
        rx_en = ts_bit_en;
      end
      default: begin
        rx_en = 1'b0;
      end
    endcase
    rx_en = rx_en && r.ctrl[HDR_CTRL_EN];
    raw_n = {rx_bit, r.raw[7:1]};
    is_flag = raw_n == HDR_FLAG;
    is_abort = rx_bit && (r.ones == HDR_ONES_PRE_ABORT);
    stuffed = !rx_bit && (r.ones == HDR_ONES_STUFF);
    st = '0;
    st[HDR_ST_EMPTY] = !fifo_rv;
    st[HDR_ST_OVR] = r.istat[HDR_INT_OVR];
    st[HDR_ST_IRQ] = irq;
    st[HDR_ST_WFIRST] = r.wr_first;
    st[HDR_ST_WEOM] = r.wr_eom;
    st[HDR_ST_TAG_LO +: 5] = r.last_tag;

    // Bus slave: ack one cycle after the request, write at the ack edge;
    // read side effects act when the data is captured so none is lost
    n.ack = acc && !r.ack;
    if (acc && !r.ack) begin
      if (adr == HDR_OFF_CTRL) begin
        n.dat = {27'h0, r.ctrl};
      end else if (adr == HDR_OFF_ADDR) begin
        n.dat = {16'h0, r.addr2, r.addr1};
      end else if (adr == HDR_OFF_THRESH) begin
        n.dat = {24'h0, r.thr};
      end else if (adr == HDR_OFF_STATUS) begin
        n.dat = st;
        if (!wb_we_i) begin
          n.wr_first = 1'b0;
          n.wr_eom = 1'b0;
        end
      end else if (adr == HDR_OFF_DATA) begin
        n.dat = {24'h0, fifo_rv ? fifo_rd[7:0] : 8'h00};
        if (!wb_we_i && fifo_rv) begin
          fifo_pop = 1'b1;
          n.last_tag = fifo_rd[HDR_TAG_NONINT:HDR_TAG_ABORT];
        end
      end else if (adr == HDR_OFF_INT_STAT) begin
        n.dat = {28'h0, r.istat};
      end else if (adr == HDR_OFF_INT_MASK) begin
        n.dat = {28'h0, r.imask};
      end else begin
        n.dat = '0;
      end
    end
    if (acc && r.ack && wb_we_i) begin
      if (adr == HDR_OFF_CTRL) begin
        wm = hdr_merge({27'h0, r.ctrl}, wb_dat_i, wb_sel_i);
        n.ctrl = wm[4:0];
      end else if (adr == HDR_OFF_ADDR) begin
        wm = hdr_merge({16'h0, r.addr2, r.addr1}, wb_dat_i, wb_sel_i);
        {n.addr2, n.addr1} = wm[15:0];
      end else if (adr == HDR_OFF_THRESH) begin
        wm = hdr_merge({24'h0, r.thr}, wb_dat_i, wb_sel_i);
        n.thr = wm[7:0];
      end else if (adr == HDR_OFF_INT_STAT) begin
        n.istat = r.istat & ~wm[HDR_INT_W-1:0];
      end else if (adr == HDR_OFF_INT_MASK) begin
        wm = hdr_merge({28'h0, r.imask}, wb_dat_i, wb_sel_i);
        n.imask = wm[HDR_INT_W-1:0];
      end
    end

    // Serial receive: flag hunt, zero deletion, byte assembly
    if (rx_en) begin
      n.raw = raw_n;
      n.ones = !rx_bit ? 3'h0 :
               (r.ones == HDR_ONES_MAX) ? HDR_ONES_MAX : r.ones + 1'b1;
      case (r.state)
        HDR_HUNT: begin
          if (is_flag) begin
            n.state = HDR_IDLE;
            n.cnt = '0;
          end
        end
        HDR_IDLE: begin
          if (is_abort) begin
            n.state = HDR_HUNT;
          end else if (is_flag) begin
            n.cnt = '0;
          end else if (!stuffed) begin
            n.sh = {rx_bit, r.sh[7:1]};
            n.cnt = (r.cnt == HDR_BITS_BYTE) ? 4'h1 : r.cnt + 1'b1;
            if (r.cnt == HDR_BITS_LAST) begin
              n.state = HDR_DATA;
              n.pend = n.sh;
              n.pend_first = 1'b1;
              n.crc = HDR_CRC_INIT;
              n.store = !r.ctrl[HDR_CTRL_AM_EN] ||
                hdr_addr_hit(n.sh, r.addr1, r.ctrl[HDR_CTRL_SAPI]) ||
                hdr_addr_hit(n.sh, r.addr2, r.ctrl[HDR_CTRL_SAPI]) ||
                (n.sh == HDR_BCAST);
            end
          end
        end
        HDR_DATA: begin
          fifo_wd[7:0] = r.pend;
          fifo_wd[HDR_TAG_FIRST] = r.pend_first;
          if (is_abort) begin
            n.state = HDR_HUNT;
            fifo_wr = r.store;
            fifo_wd[HDR_TAG_ABORT] = 1'b1;
            n.istat[HDR_INT_ABT] = r.store;
          end else if (is_flag) begin
            n.state = HDR_IDLE;
            n.cnt = '0;
            fifo_wr = r.store;
            fifo_wd[HDR_TAG_EOM] = 1'b1;
            fifo_wd[HDR_TAG_FCSOK] =
              hdr_crc_byte(r.crc, r.pend) == HDR_CRC_GOOD;
            fifo_wd[HDR_TAG_NONINT] = r.cnt != HDR_BITS_LAST;
            if (r.store) begin
              n.istat[HDR_INT_EOM] = 1'b1;
            end
          end else if (!stuffed) begin
            n.sh = {rx_bit, r.sh[7:1]};
            n.cnt = (r.cnt == HDR_BITS_BYTE) ? 4'h1 : r.cnt + 1'b1;
            if (r.cnt == HDR_BITS_LAST) begin
              fifo_wr = r.store;
              n.crc = hdr_crc_byte(r.crc, r.pend);
              n.pend = n.sh;
              n.pend_first = 1'b0;
            end
          end
        end
        default: begin
          n.state = HDR_HUNT;
        end
      endcase
    end
    if (fifo_wr && !fifo_wready) begin
      n.istat[HDR_INT_OVR] = 1'b1;
    end
    if (fifo_wr && fifo_wready) begin
      n.wr_first = n.wr_first || fifo_wd[HDR_TAG_FIRST];
      n.wr_eom = n.wr_eom || fifo_wd[HDR_TAG_EOM];
    end
    if (r.thr != 8'h00 && fifo_level >= LW'(r.thr)) begin
      n.istat[HDR_INT_THR] = 1'b1;
    end
    if (!r.ctrl[HDR_CTRL_EN]) begin
      n.state = HDR_HUNT;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      r <= '0;
      r.state <= HDR_HUNT;
      r.ctrl <= HDR_CTRL_RST;
      r.addr1 <= HDR_ADDR_RST;
      r.addr2 <= HDR_ADDR_RST;
      r.thr <= HDR_THR_RST;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_reg);

  a_ack_single: assert property (r.ack |=> !r.ack)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (acc && !r.ack |=> r.ack)
    else $error("ack not given one cycle after request");
  a_abort_ends: assert property (
    rx_en && r.state == HDR_DATA && is_abort |=> r.state == HDR_HUNT)
    else $error("abort did not end packet");
  a_stuff_dropped: assert property (
    rx_en && r.state == HDR_DATA && stuffed |=> $stable(r.cnt))
    else $error("stuffed zero was counted");
  a_first_byte: assert property (
    rx_en && r.state == HDR_IDLE && !is_flag && !is_abort && !stuffed &&
    r.cnt == HDR_BITS_LAST |=> r.state == HDR_DATA && r.pend_first)
    else $error("first data byte not recognised");
  a_filter_drop: assert property (
    r.state == HDR_DATA && !r.store |-> !fifo_wr)
    else $error("filtered packet written");
  a_thresh_irq: assert property (
    r.thr != 8'h00 && fifo_level >= LW'(r.thr) |=> r.istat[HDR_INT_THR])
    else $error("threshold interrupt missing");
  a_close_irq: assert property (
    rx_en && r.state == HDR_DATA && is_flag && !is_abort && r.store
    |=> r.istat[HDR_INT_EOM] && r.state == HDR_IDLE)
    else $error("closing flag not flagged");
  a_ovr_irq: assert property (
    fifo_wr && !fifo_wready |=> r.istat[HDR_INT_OVR])
    else $error("overrun not flagged");
  a_pop_tag: assert property (
    fifo_pop |=> r.last_tag == $past(fifo_rd[HDR_TAG_NONINT:HDR_TAG_ABORT]))
    else $error("read tag not shown");

  c_packet_end: cover property (r.state == HDR_DATA ##1 r.state == HDR_IDLE);
  c_abort: cover property (r.state == HDR_DATA ##1 r.state == HDR_HUNT);
  c_overrun: cover property (fifo_wr && !fifo_wready);
  c_pop: cover property (fifo_pop);
endmodule
`default_nettype wire

// ---- hdr_link_model.sv ----
// Line framer model sending flags, stuffed bytes, FCS and aborts
`timescale 1ns/1ps
`default_nettype none
module hdr_link_model
  import hdr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  output logic ser_bit,
  output logic ser_en
);
  int gap = 1;
  int ones = 0;
  logic [15:0] fcs;

  initial begin
    ser_bit = 1'b1;
    ser_en = 1'b0;
  end

  // One-cycle valid; afterwards the line shows the inverse of the bit
  task automatic put_bit(input logic b);
    @(posedge core_clk);
    ser_bit <= b;
    ser_en <= rst_n;
    @(posedge core_clk);
    ser_en <= 1'b0;
    ser_bit <= ~b;
    repeat (gap) @(posedge core_clk);
  endtask

  task automatic put_byte(input logic [7:0] v, input bit stuff);
    for (int i = 0; i < 8; i++) begin
      put_bit(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        put_bit(1'b0);
        ones = 0;
      end
    end
  endtask

  task automatic flag();
    put_byte(HDR_FLAG, 1'b0);
    ones = 0;
  endtask

  task automatic frame(input logic [7:0] d[$], input bit bad, input int extra);
    logic [15:0] crc;
    logic fb;
    crc = HDR_CRC_INIT;
    flag();
    flag();
    foreach (d[k]) begin
      for (int i = 0; i < 8; i++) begin
        fb = crc[0] ^ d[k][i];
        crc = {1'b0, crc[15:1]} ^ (fb ? HDR_CRC_POLY : 16'h0000);
      end
      put_byte(d[k], 1'b1);
    end
    fcs = ~crc ^ {15'h0000, bad};
    put_byte(fcs[7:0], 1'b1);
    put_byte(fcs[15:8], 1'b1);
    repeat (extra) put_bit(1'b0);
    flag();
  endtask

  // Eight unstuffed ones in mid-packet, then a flag to resynchronise
  task automatic abort_after(input logic [7:0] d[$]);
    flag();
    foreach (d[k]) put_byte(d[k], 1'b1);
    put_byte(8'hff, 1'b0);
    flag();
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the HDLC data link receiver
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module tb_top
  import hdr_pkg::*;
;
  logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic ser_bit, ser_en, fdl_bit, sa_bit, ts_bit;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [1:0] src;
  logic [7:0] pl[$], exp_q[$];
  int fails = 0;
  int tests_run = 0;

  // Unselected sources see the inverted stream
  assign fdl_bit = (src == 2'h0) ? ser_bit : ~ser_bit;
  assign sa_bit = (src == 2'h1) ? ser_bit : ~ser_bit;
  assign ts_bit = (src == 2'h2) ? ser_bit : ~ser_bit;

  hdr_link_model link (.core_clk(core_clk), .rst_n(rst_n),
    .ser_bit(ser_bit), .ser_en(ser_en));
  hdr_hdlc_receiver_unit dut (.core_clk(core_clk), .rst_n(rst_n),
    .fdl_bit(fdl_bit), .fdl_bit_en(ser_en), .sa_bit(sa_bit),
    .sa_bit_en(ser_en), .ts_bit(ts_bit), .ts_bit_en(ser_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      `CHK(wb_ack_o, 1'b1)
      print_verdict();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Flush the FIFO and clear pending events, then enable with ctl
  task automatic restart(input logic [31:0] ctl);
    wb(1'b1, HDR_OFF_CTRL, 32'h0);
    wb(1'b1, HDR_OFF_INT_STAT, 32'hf);
    wb(1'b1, HDR_OFF_CTRL, ctl);
  endtask

  task automatic send(input bit bad, input int extra);
    link.frame(pl, bad, extra);
    exp_q = pl;
    exp_q.push_back(link.fcs[7:0]);
    exp_q.push_back(link.fcs[15:8]);
    // Trailing bits and the closing flag's leading bits fill one more byte
    if (extra > 0) exp_q.push_back(8'(8'hff << (extra + 1)));
  endtask

  task automatic expect_frame(input bit ok, input bit nonint);
    wb(1'b0, HDR_OFF_INT_STAT, 32'h0);
    `CHK(q[HDR_INT_EOM], 1'b1)
    wb(1'b0, HDR_OFF_STATUS, 32'h0);
    `CHK(q[4:3], 2'h3)
    foreach (exp_q[k]) begin
      wb(1'b0, HDR_OFF_DATA, 32'h0);
      `CHK(q[7:0], exp_q[k])
      wb(1'b0, HDR_OFF_STATUS, 32'h0);
      `CHK(q[7:5], {k == exp_q.size() - 1, k == 0, 1'b0})
    end
    `CHK(q[9:8], {nonint, ok})
    `CHK(q[HDR_ST_EMPTY], 1'b1)
  endtask

  task automatic t_regs();
    logic [7:0] offs[7] = '{HDR_OFF_CTRL, HDR_OFF_ADDR, HDR_OFF_THRESH,
      HDR_OFF_STATUS, HDR_OFF_INT_STAT, HDR_OFF_INT_MASK, 8'h1c};
    logic [31:0] rv[7] = '{32'h0, 32'h0, {24'h0, HDR_THR_RST}, 32'h1,
      32'h0, 32'h0, 32'h0};
    wb(1'b1, 8'h1c, 32'hffff_ffff);
    wb(1'b1, HDR_OFF_STATUS, 32'hffff_ffff);
    foreach (offs[i]) begin
      wb(1'b0, offs[i], 32'h0);
      `CHK(q, rv[i])
    end
    $display("test regs finished");
  endtask

  task automatic t_sources();
    pl = {8'h7e, 8'hff, 8'h1f, 8'h00};
    for (int s = 0; s < 3; s++) begin
      src = s[1:0];
      link.gap = 2 * s;
      restart({27'h0, src, 3'h1});
      send(1'b0, 0);
      expect_frame(1'b1, 1'b0);
    end
    link.gap = 1;
    src = 2'h3;
    restart(32'h19);
    send(1'b0, 0);
    wb(1'b0, HDR_OFF_STATUS, 32'h0);
    `CHK(q[HDR_ST_EMPTY], 1'b1)
    src = 2'h0;
    $display("test sources finished");
  endtask

  task automatic t_fcs();
    pl = '{8'h12, 8'h34};
    restart(32'h1);
    send(1'b1, 0);
    expect_frame(1'b0, 1'b0);
    wb(1'b1, HDR_OFF_INT_STAT, 32'hf);
    send(1'b0, 3);
    expect_frame(1'b0, 1'b1);
    $display("test fcs finished");
  endtask

  task automatic t_addr();
    logic [7:0] fb[9] = '{8'h30, 8'h44, 8'hff, 8'h31, 8'h33, 8'h31, 8'h33,
      8'h47, 8'h35};
    logic st[9] = '{1, 1, 1, 0, 0, 1, 1, 1, 0};
    wb(1'b1, HDR_OFF_ADDR, 32'h4430);
    foreach (fb[i]) begin
      restart(i < 5 ? 32'h3 : 32'h7);
      pl = {fb[i], 8'h55};
      send(1'b0, 0);
      wb(1'b0, HDR_OFF_INT_STAT, 32'h0);
      `CHK(q[HDR_INT_EOM], st[i])
      wb(1'b0, HDR_OFF_DATA, 32'h0);
      `CHK(q[7:0], st[i] ? fb[i] : 8'h00)
    end
    $display("test address finished");
  endtask

  task automatic t_abort();
    int n;
    n = 0;
    restart(32'h1);
    link.abort_after({8'h11, 8'h22, 8'h33});
    wb(1'b0, HDR_OFF_INT_STAT, 32'h0);
    `CHK(q[HDR_INT_ABT:HDR_INT_EOM], 2'h2)
    wb(1'b0, HDR_OFF_DATA, 32'h0);
    `CHK(q[7:0], 8'h11)
    wb(1'b0, HDR_OFF_STATUS, 32'h0);
    while (q[HDR_ST_EMPTY] !== 1'b1 && n < 8) begin
      wb(1'b0, HDR_OFF_DATA, 32'h0);
      wb(1'b0, HDR_OFF_STATUS, 32'h0);
      n++;
    end
    `CHK(q[HDR_ST_EMPTY], 1'b1)
    `CHK(q[HDR_ST_TAG_LO], 1'b1)
    $display("test abort finished");
  endtask

  task automatic t_irq();
    restart(32'h1);
    wb(1'b1, HDR_OFF_THRESH, 32'h5);
    pl = '{8'h01, 8'h02, 8'h03};
    send(1'b0, 0);
    wb(1'b0, HDR_OFF_INT_STAT, 32'h0);
    `CHK(q[HDR_INT_THR], 1'b1)
    `CHK(irq, 1'b0)
    wb(1'b1, HDR_OFF_INT_MASK, 32'h1);
    @(posedge core_clk);
    `CHK(irq, 1'b1)
    wb(1'b0, HDR_OFF_STATUS, 32'h0);
    `CHK(q[HDR_ST_IRQ], 1'b1)
    restart(32'h1);
    @(posedge core_clk);
    `CHK(irq, 1'b0)
    wb(1'b0, HDR_OFF_INT_STAT, 32'h0);
    `CHK(q, 32'h0)
    $display("test interrupt finished");
  endtask

  task automatic t_ovr();
    int n;
    n = 0;
    restart(32'h1);
    wb(1'b1, HDR_OFF_THRESH, 32'h0);
    pl = {};
    for (int i = 0; i < 130; i++) pl.push_back(i[7:0]);
    send(1'b0, 0);
    wb(1'b0, HDR_OFF_INT_STAT, 32'h0);
    `CHK(q[HDR_INT_OVR], 1'b1)
    wb(1'b0, HDR_OFF_STATUS, 32'h0);
    `CHK(q[HDR_ST_OVR], 1'b1)
    while (q[HDR_ST_EMPTY] !== 1'b1 && n < 200) begin
      wb(1'b0, HDR_OFF_DATA, 32'h0);
      `CHK(q[7:0], n[7:0])
      n++;
      wb(1'b0, HDR_OFF_STATUS, 32'h0);
    end
    `CHK(n, HDR_FIFO_DEPTH)
    $display("test overrun finished");
  endtask

  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    src = 2'h0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_sources();
    t_fcs();
    t_addr();
    t_abort();
    t_irq();
    t_ovr();
    print_verdict();
  end
endmodule
`default_nettype wire
